// File: rtl/bbex_consts.svh
// constants for the bit-band and exclusive access block
// assumes a 32-bit byte-addressed memory map
`ifndef BBEX_CONSTS_SVH
`define BBEX_CONSTS_SVH

// -------------------------------------------------------------
// alias windows, addr[31:25]
// -------------------------------------------------------------
`define BBEX_SRAM_ALIAS_TOP 7'h11
`define BBEX_PERI_ALIAS_TOP 7'h21
`define BBEX_BB_GAP 8'h00

// -------------------------------------------------------------
// answers and lanes
// -------------------------------------------------------------
`define BBEX_ALIAS_RD_SET 32'h0000_0001
`define BBEX_ALIAS_RD_CLR 32'h0000_0000
`define BBEX_STAT_OK 1'b0
`define BBEX_STAT_FAIL 1'b1
`define BBEX_BE_ALL 4'hf
`define BBEX_BE_HALF 4'h3
`define BBEX_BE_BYTE 4'h1

`endif

// File: rtl/bbex_pkg.sv
// types shared by the bit-band and exclusive access block
// assumes the core issues one request at a time
package bbex_pkg;

    typedef enum logic [1:0] {sz_byte, sz_half, sz_word} bbex_size_t;

    // load_exclusive_word/half/byte and store_exclusive_word/half/byte are op plus size
    typedef enum logic [1:0] {op_plain, op_load_exclusive, op_store_exclusive} bbex_op_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        bbex_size_t size;
        bbex_op_t op;
        logic write;
        logic fetch;
    } bbex_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic status;
    } bbex_rsp_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0] be;
        logic we;
    } bbex_mem_t;

endpackage

// File: rtl/bbex_exmon.sv
// exclusive access monitor: one tag for the local core
// assumes set, store and clear strobes are single-cycle pulses
`timescale 1ns/1ps
module bbex_exmon (
    input wire logic clk,
    input wire logic rstn,
    input wire logic set_tag,
    input wire logic store_done,
    input wire logic clear_cmd,
    input wire logic exc_taken,
    output logic tag_q
);

    // -------------------------------------------------------------
    // tag
    // -------------------------------------------------------------
    // an exception always wins so an interrupted sequence cannot pass
    always_ff @(posedge clk)
    begin
        if (!rstn)
            tag_q <= 1'b0; // R19
        else if (exc_taken)
            tag_q <= 1'b0; // R11
        else if (set_tag)
            tag_q <= 1'b1; // R6
        else if (clear_cmd || store_done)
            tag_q <= 1'b0; // R9 R10
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_ldex_sets_tag: assert property (set_tag && !exc_taken |=> tag_q) // R6
        else $error("load exclusive did not set the tag");
    chk_clear_exclusive_tag_drops_tag: assert property (clear_cmd && !set_tag && !exc_taken |=> !tag_q) // R9
        else $error("clear exclusive left the tag set");
    chk_store_drops_tag: assert property (store_done && !set_tag |=> !tag_q) // R10
        else $error("store exclusive left the tag set");
    chk_exc_drops_tag: assert property (exc_taken |=> !tag_q) // R11
        else $error("exception left the tag set");
    chk_reset_tag_clear: assert property (@(posedge clk) disable iff (1'b0) !rstn |=> !tag_q) // R19
        else $error("tag not clear after reset");

endmodule

// File: rtl/bbex_top.sv
// bit-band alias decoder and exclusive access path between core and memory
// assumes memory answers a read with mem_rdata valid two cycles after mem_req
// (one cycle after the edge that samples mem_req) and takes writes at once
//
// Operation
// R1 - alias write changes exactly one bit of the bit-band memory; a store exclusive to an alias is not remapped and writes there
// R2 - targeted bit takes bit 0 of the written alias value
// R3 - bits 31:1 of an alias write value are ignored
// R4 - alias read returns 0x0 when bit clear, 0x1 when set
// R5 - memory is little-endian, lowest byte address holds least significant byte
// R6 - load exclusive returns data and sets the exclusive tag
// R7 - store exclusive writes with status 0 only if tag held, else status 1
// R8 - exclusive loads and stores work on word, halfword and byte
// R9 - clear exclusive removes the tag so a later store exclusive fails
// R10 - every store exclusive removes the tag, pass or fail
// R11 - a taken exception removes the tag
// R12 - requester pairs each load exclusive with store exclusive of same size
// R13 - requester retries the whole sequence after a failed store exclusive
// R14 - semaphore claim holds only if the store exclusive reports success
// R15 - alias offset is byte offset times 32 plus bit number times 4
// R16 - lowest 1 MB of sram and peripheral space each have an alias window
// R17 - alias write is a read-modify-write of the underlying word; a store exclusive to an alias address writes the alias address directly
// R18 - only data accesses are remapped, instruction fetches pass unchanged
// R19 - exclusive tag is clear after reset
`timescale 1ns/1ps
`include "bbex_consts.svh"
module bbex_top (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire bbex_pkg::bbex_req_t req,
    output logic req_ready_q,
    input wire logic clear_exclusive_tag,
    input wire logic exception_taken,
    output logic rsp_valid_q,
    output bbex_pkg::bbex_rsp_t rsp_q,
    output logic mem_req_q,
    output bbex_pkg::bbex_mem_t mem_q,
    input wire logic [31:0] mem_rdata,
    output logic excl_tag
);

    typedef enum {st_idle, st_wait, st_data} bbex_state_t;

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    function automatic logic is_alias(input logic [31:0] a);
        is_alias = (a[31:25] == `BBEX_SRAM_ALIAS_TOP) || (a[31:25] == `BBEX_PERI_ALIAS_TOP); // R16
    endfunction

    function automatic logic [31:0] target_addr(input logic [31:0] a);
        target_addr = {a[31:28], `BBEX_BB_GAP, a[24:5]}; // R15
    endfunction

    function automatic logic [3:0] lane_be(input bbex_pkg::bbex_size_t s, input logic [1:0] l);
        case (s)
            bbex_pkg::sz_word: lane_be = `BBEX_BE_ALL;
            bbex_pkg::sz_half: lane_be = `BBEX_BE_HALF << {l[1], 1'b0};
            bbex_pkg::sz_byte: lane_be = `BBEX_BE_BYTE << l;
            default: lane_be = `BBEX_BE_ALL;
        endcase
    endfunction

    bbex_state_t state_q;
    bbex_pkg::bbex_req_t cur_q;
    logic cur_alias_q;
    logic accept;
    logic remap;
    logic is_store_excl;
    logic store_fail;
    logic [31:0] req_word;
    logic [31:0] wdata_rep;
    logic [31:0] shifted;
    logic [31:0] lane_data;
    logic [31:0] merged;
    logic [4:0] bidx;
    logic alias_bit;

    assign accept = req_valid && req_ready_q;
    // fetches stay on their own address: only data is remapped
    assign remap = is_alias(req.addr) && !req.fetch; // R18
    assign is_store_excl = req.op == bbex_pkg::op_store_exclusive;
    assign store_fail = is_store_excl && !excl_tag; // R7
    // a store exclusive to an alias word is not remapped: it cannot read-modify-write in one cycle,
    // so it must never land a full word on the bit-band memory
    assign req_word = (remap && !is_store_excl) ? target_addr(req.addr) : req.addr; // R1
    // bit index within the fetched word: byte lane then bit number
    assign bidx = {cur_q.addr[6:5], cur_q.addr[4:2]};
    assign alias_bit = mem_rdata[bidx];
    assign shifted = mem_rdata >> {cur_q.addr[1:0], 3'b000}; // R5

    // -------------------------------------------------------------
    // lane steering
    // -------------------------------------------------------------
    always_comb
    begin
        case (req.size)
            bbex_pkg::sz_byte: wdata_rep = {4{req.wdata[7:0]}}; // R8
            bbex_pkg::sz_half: wdata_rep = {2{req.wdata[15:0]}};
            default: wdata_rep = req.wdata;
        endcase
    end

    always_comb
    begin
        case (cur_q.size)
            bbex_pkg::sz_byte: lane_data = {24'h0, shifted[7:0]}; // R8
            bbex_pkg::sz_half: lane_data = {16'h0, shifted[15:0]};
            default: lane_data = mem_rdata;
        endcase
    end

    // only the addressed bit follows wdata[0]; the rest keep memory contents
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_merge
            assign merged[i] = (bidx == 5'(i)) ? cur_q.wdata[0] : mem_rdata[i]; // R1 R2 R3
        end
    endgenerate

    // -------------------------------------------------------------
    // sequencing
    // -------------------------------------------------------------
    // reads and alias writes both wait for data; plain writes finish at once
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_q <= st_idle;
            req_ready_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                st_idle:
                    if (accept && (!req.write || (remap && !is_store_excl)))
                    begin
                        state_q <= st_wait;
                        req_ready_q <= 1'b0;
                    end
                st_wait:
                    state_q <= st_data;
                st_data:
                begin
                    state_q <= st_idle;
                    req_ready_q <= 1'b1;
                end
                default:
                begin
                    state_q <= st_idle;
                    req_ready_q <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cur_q <= '0;
            cur_alias_q <= 1'b0;
        end
        else if (accept)
        begin
            cur_q <= req;
            cur_alias_q <= remap && !is_store_excl;
        end
    end

    // -------------------------------------------------------------
    // memory port
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            mem_req_q <= 1'b0;
            mem_q <= '0;
        end
        else
        begin
            mem_req_q <= 1'b0;
            // a failed store exclusive never reaches memory
            if (accept && !store_fail) // R7
            begin
                mem_req_q <= 1'b1;
                mem_q.addr <= {req_word[31:2], 2'b00};
                // alias writes start with a read of the whole word
                mem_q.we <= req.write && !(remap && !is_store_excl); // R17
                mem_q.be <= (remap && !is_store_excl) ? `BBEX_BE_ALL : lane_be(req.size, req.addr[1:0]); // R5 R8
                mem_q.wdata <= wdata_rep;
            end
            else if (state_q == st_data && cur_alias_q && cur_q.write)
            begin
                mem_req_q <= 1'b1;
                mem_q.we <= 1'b1;
                mem_q.be <= `BBEX_BE_ALL;
                mem_q.wdata <= merged; // R1 R17
            end
        end
    end

    // -------------------------------------------------------------
    // answers
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end
        else
        begin
            rsp_valid_q <= 1'b0;
            // plain writes and store exclusives answer at once; reads and alias writes wait for memory
            if (accept && req.write && !(remap && !is_store_excl))
            begin
                rsp_valid_q <= 1'b1;
                rsp_q.rdata <= '0;
                rsp_q.status <= store_fail ? `BBEX_STAT_FAIL : `BBEX_STAT_OK; // R7
            end
            else if (state_q == st_data)
            begin
                rsp_valid_q <= 1'b1;
                rsp_q.status <= `BBEX_STAT_OK;
                if (cur_alias_q)
                    rsp_q.rdata <= alias_bit ? `BBEX_ALIAS_RD_SET : `BBEX_ALIAS_RD_CLR; // R4
                else
                    rsp_q.rdata <= lane_data; // R5 R6
            end
        end
    end

    // -------------------------------------------------------------
    // exclusive monitor
    // -------------------------------------------------------------
    bbex_exmon u_exmon (
        .clk(clk),
        .rstn(rstn),
        .set_tag(accept && req.op == bbex_pkg::op_load_exclusive),
        .store_done(accept && is_store_excl),
        .clear_cmd(clear_exclusive_tag),
        .exc_taken(exception_taken),
        .tag_q(excl_tag)
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_stex_fail_path: assert property (accept && is_store_excl && !excl_tag // R7
        |=> rsp_valid_q && rsp_q.status && !mem_req_q)
        else $error("failed store exclusive wrote or gave wrong status");
    chk_stex_pass_path: assert property (accept && is_store_excl && excl_tag // R7
        |=> rsp_valid_q && !rsp_q.status && mem_req_q && mem_q.we)
        else $error("store exclusive with tag did not write");
    chk_alias_read_val: assert property (state_q == st_data && cur_alias_q && !cur_q.write // R4
        |=> rsp_valid_q && rsp_q.rdata == {31'h0, $past(alias_bit)})
        else $error("alias read value wrong");
    chk_alias_one_bit: assert property (state_q == st_data && cur_alias_q && cur_q.write // R1
        |=> mem_req_q && mem_q.we && ((mem_q.wdata ^ $past(mem_rdata)) & ~(32'h1 << bidx)) == 32'h0)
        else $error("alias write touched other bits");
    chk_alias_bit_zero: assert property (state_q == st_data && cur_alias_q && cur_q.write // R2
        |=> mem_q.wdata[bidx] == cur_q.wdata[0])
        else $error("alias bit not taken from bit 0");
    chk_alias_addr_map: assert property (accept && remap && !is_store_excl // R15
        |=> mem_q.addr[27:20] == 8'h0 && mem_q.addr[31:28] == $past(req.addr[31:28])
        && ({4'h0, mem_q.addr[27:0]} << 5) == ($past(req.addr) & 32'h01ff_ff80))
        else $error("alias address mapped wrongly");
    chk_fetch_direct: assert property (accept && req.fetch // R18
        |=> mem_q.addr[31:2] == $past(req.addr[31:2]))
        else $error("instruction fetch was remapped");
    chk_half_lane_hi: assert property (state_q == st_data && !cur_alias_q // R5
        && cur_q.size == bbex_pkg::sz_half && cur_q.addr[1:0] == 2'h2
        |=> rsp_q.rdata == {16'h0, $past(mem_rdata[31:16])})
        else $error("upper halfword lane wrong");
    chk_alias_write_rd: assert property (accept && remap && req.write && !is_store_excl // R17
        |=> mem_req_q && !mem_q.we && mem_q.be == `BBEX_BE_ALL)
        else $error("alias write did not start with a word read");
    chk_stex_word_addr: assert property (accept && is_store_excl && excl_tag // R1
        |=> mem_q.addr[31:2] == $past(req.addr[31:2]))
        else $error("store exclusive address was remapped");
    chk_byte_zero_ext: assert property (state_q == st_data && !cur_alias_q && cur_q.size == bbex_pkg::sz_byte // R8
        |=> rsp_q.rdata[31:8] == 24'h0)
        else $error("byte read not zero extended");
    chk_half_zero_ext: assert property (state_q == st_data && !cur_alias_q && cur_q.size == bbex_pkg::sz_half // R8
        |=> rsp_q.rdata[31:16] == 16'h0)
        else $error("halfword read not zero extended");

    cov_alias_write: cover property (state_q == st_data && cur_alias_q && cur_q.write);
    cov_stex_pass: cover property (accept && is_store_excl && excl_tag);
    cov_stex_fail: cover property (accept && is_store_excl && !excl_tag);
    cov_ldex_byte: cover property (accept && req.op == bbex_pkg::op_load_exclusive
        && req.size == bbex_pkg::sz_byte);
    cov_peri_alias: cover property (accept && remap && req.addr[31:25] == `BBEX_PERI_ALIAS_TOP);

endmodule

// File: verification/bbex_mem_model.sv
// memory partner for the bit-band and exclusive access block
// assumes word-aligned addresses and one access per mem_req_q pulse
`timescale 1ns/1ps
module bbex_mem_model (
    input wire logic clk,
    input wire logic mem_req_q,
    input wire bbex_pkg::bbex_mem_t mem_q,
    output logic [31:0] mem_rdata
);
    // -------------------------------------------------------------
    // storage, preloaded by the bench through the hierarchy
    // -------------------------------------------------------------
    logic [31:0] mem [logic [31:0]];
    // released bus toggles every cycle so a late sample never looks valid
    logic [31:0] idle_q = 32'h3c3c_c3c3;

    always @(posedge clk)
    begin
        idle_q <= ~idle_q;
        if (mem_req_q && mem_q.we)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (mem_q.be[i])
                begin
                    mem[mem_q.addr][8*i +: 8] = mem_q.wdata[8*i +: 8];
                end
            end
        end
        // read data stands for exactly the cycle after the request
        mem_rdata <= (mem_req_q && !mem_q.we) ? mem[mem_q.addr] : idle_q;
    end
endmodule

// File: verification/bbex_top_tb_top.sv
// self-checking bench for the bit-band and exclusive access block
// assumes the memory partner model answers reads one cycle after mem_req_q
`timescale 1ns/1ps
module bbex_top_tb_top;
    logic clk;
    logic rstn;
    logic req_valid;
    bbex_pkg::bbex_req_t req;
    logic req_ready_q;
    logic clear_exclusive_tag;
    logic exception_taken;
    logic rsp_valid_q;
    bbex_pkg::bbex_rsp_t rsp_q;
    logic mem_req_q;
    bbex_pkg::bbex_mem_t mem_q;
    logic [31:0] mem_rdata;
    logic excl_tag;
    bbex_pkg::bbex_rsp_t r;
    int fail_count;
    int num_checks;

    bbex_top DUT (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q),
        .clear_exclusive_tag(clear_exclusive_tag), .exception_taken(exception_taken),
        .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .mem_req_q(mem_req_q), .mem_q(mem_q),
        .mem_rdata(mem_rdata), .excl_tag(excl_tag));
    bbex_mem_model mem_i (.clk(clk), .mem_req_q(mem_req_q), .mem_q(mem_q), .mem_rdata(mem_rdata));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // -------------------------------------------------------------
    // reporting
    // -------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // -------------------------------------------------------------
    // one request, held until taken, then wait for its answer
    // -------------------------------------------------------------
    task automatic xfer(input logic [31:0] a, input logic [31:0] d, input bbex_pkg::bbex_size_t s,
                        input bbex_pkg::bbex_op_t o, input logic w, input logic f);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{addr: a, wdata: d, size: s, op: o, write: w, fetch: f};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (req_ready_q !== 1'b1 && n < 20);
        req_valid <= 1'b0;
        // outputs read here still hold their pre-edge values, so no race
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp_valid_q !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            fail_count++;
            $display("wait limit hit at %0t", $time);
            print_verdict;
        end
        r = rsp_q;
        // the memory model commits a write at this same edge, so let it pass before memory is read back
        @(posedge clk);
    endtask

    task automatic pulse(input logic exc);
        @(posedge clk);
        exception_taken <= exc;
        clear_exclusive_tag <= !exc;
        @(posedge clk);
        exception_taken <= 1'b0;
        clear_exclusive_tag <= 1'b0;
        // the tag drops at the edge that samples the pulse; look only after it
        @(posedge clk);
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_reset;
        chk_bit(excl_tag, 1'b0);
        chk_bit(rsp_valid_q | mem_req_q, 1'b0);
        rstn <= 1'b1;
        mem_i.mem[32'h2000_0300] = 32'h0000_0000;
        xfer(32'h2000_0300, 32'hdead_beef, bbex_pkg::sz_word, bbex_pkg::op_store_exclusive, 1'b1, 1'b0);
        chk_bit(r.status, 1'b1);
        chk_word(mem_i.mem[32'h2000_0300], 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_alias;
        // alias, written value, target word, word before, word after, alias read
        logic [31:0] tab [4][6] = '{
            '{32'h2200_00ac, 32'h0000_000e, 32'h2000_0004, 32'ha5a5_5a5a, 32'ha5a5_525a, 32'h0},
            '{32'h2200_00ac, 32'h0000_00ff, 32'h2000_0004, 32'ha5a5_525a, 32'ha5a5_5a5a, 32'h1},
            '{32'h23ff_fffc, 32'h0000_0001, 32'h200f_fffc, 32'h0000_0000, 32'h8000_0000, 32'h1},
            '{32'h4200_005c, 32'hffff_fffe, 32'h4000_0000, 32'hffff_ffff, 32'hff7f_ffff, 32'h0}};
        for (int i = 0; i < 4; i++)
        begin
            mem_i.mem[tab[i][2]] = tab[i][3];
            xfer(tab[i][0], tab[i][1], bbex_pkg::sz_word, bbex_pkg::op_plain, 1'b1, 1'b0);
            chk_word(mem_i.mem[tab[i][2]], tab[i][4]);
            xfer(tab[i][0], 32'h0, bbex_pkg::sz_word, bbex_pkg::op_plain, 1'b0, 1'b0);
            chk_word(r.rdata, tab[i][5]);
        end
        $display("test alias done");
    endtask

    task automatic t_fetch;
        mem_i.mem[32'h2200_0010] = 32'h1234_5678;
        xfer(32'h2200_0010, 32'h0, bbex_pkg::sz_word, bbex_pkg::op_plain, 1'b0, 1'b1);
        chk_word(r.rdata, 32'h1234_5678);
        $display("test fetch done");
    endtask

    task automatic t_sizes;
        bbex_pkg::bbex_size_t sz [3] = '{bbex_pkg::sz_word, bbex_pkg::sz_half, bbex_pkg::sz_byte};
        // address, load value, store value, word after
        logic [31:0] tab [3][4] = '{
            '{32'h2000_0100, 32'h4433_2211, 32'hcafe_f00d, 32'hcafe_f00d},
            '{32'h2000_0102, 32'h0000_cafe, 32'h0000_1357, 32'h1357_f00d},
            '{32'h2000_0101, 32'h0000_00f0, 32'h0000_0099, 32'h1357_990d}};
        mem_i.mem[32'h2000_0100] = 32'h4433_2211;
        for (int i = 0; i < 3; i++)
        begin
            xfer(tab[i][0], 32'h0, sz[i], bbex_pkg::op_load_exclusive, 1'b0, 1'b0);
            chk_word(r.rdata, tab[i][1]);
            chk_bit(excl_tag, 1'b1);
            xfer(tab[i][0], tab[i][2], sz[i], bbex_pkg::op_store_exclusive, 1'b1, 1'b0);
            chk_bit(r.status, 1'b0);
            chk_bit(excl_tag, 1'b0);
            chk_word(mem_i.mem[32'h2000_0100], tab[i][3]);
            xfer(tab[i][0], ~tab[i][2], sz[i], bbex_pkg::op_store_exclusive, 1'b1, 1'b0);
            chk_bit(r.status, 1'b1);
            chk_word(mem_i.mem[32'h2000_0100], tab[i][3]);
        end
        $display("test sizes done");
    endtask

    task automatic t_clear;
        xfer(32'h2000_0100, 32'h0, bbex_pkg::sz_word, bbex_pkg::op_load_exclusive, 1'b0, 1'b0);
        pulse(1'b0);
        chk_bit(excl_tag, 1'b0);
        xfer(32'h2000_0100, 32'h1111_1111, bbex_pkg::sz_word, bbex_pkg::op_store_exclusive, 1'b1, 1'b0);
        chk_bit(r.status, 1'b1);
        chk_word(mem_i.mem[32'h2000_0100], 32'h1357_990d);
        $display("test clear done");
    endtask

    task automatic t_semaphore;
        mem_i.mem[32'h2000_0200] = 32'h0000_0000;
        // first claim is cut by an exception and must be retried whole
        for (int k = 0; k < 2; k++)
        begin
            xfer(32'h2000_0200, 32'h0, bbex_pkg::sz_word, bbex_pkg::op_load_exclusive, 1'b0, 1'b0);
            chk_word(r.rdata, 32'h0000_0000);
            if (k == 0)
            begin
                pulse(1'b1);
            end
            xfer(32'h2000_0200, 32'h1, bbex_pkg::sz_word, bbex_pkg::op_store_exclusive, 1'b1, 1'b0);
            chk_bit(r.status, k == 0);
            chk_word(mem_i.mem[32'h2000_0200], (k == 0) ? 32'h0 : 32'h1);
        end
        $display("test semaphore done");
    endtask

    initial
    begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        clear_exclusive_tag = 1'b0;
        exception_taken = 1'b0;
        fail_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        t_reset;
        t_alias;
        t_fetch;
        t_sizes;
        t_clear;
        t_semaphore;
        print_verdict;
    end
endmodule
